//--- pfc_adv_pkg.sv
package pfc_adv_pkg;

  // register offsets on the command port
  localparam logic [15:0] OFS_SYNC_PERIOD_LIMIT  = 16'hfe1b;
  localparam logic [15:0] OFS_LIGHT_LOAD_FREQ    = 16'hfe1c;
  localparam logic [15:0] OFS_DITHER_PERIOD      = 16'hfe1d;
  localparam logic [15:0] OFS_SYNC_DIVIDER       = 16'hfe1e;
  localparam logic [15:0] OFS_LOW_POWER_THRESH   = 16'hfe32;
  localparam logic [15:0] OFS_LOWER_POWER_BP     = 16'hfe44;
  localparam logic [15:0] OFS_UPPER_POWER_BP     = 16'hfe45;
  localparam logic [15:0] OFS_LOW_LINE_LOWER_V   = 16'hfe46;
  localparam logic [15:0] OFS_LOW_LINE_UPPER_V   = 16'hfe47;
  localparam logic [15:0] OFS_HIGH_LINE_LOWER_V  = 16'hfe48;
  localparam logic [15:0] OFS_HIGH_LINE_UPPER_V  = 16'hfe49;
  localparam logic [15:0] OFS_FLAT_TOP_V         = 16'hfe4a;
  localparam logic [15:0] OFS_SYNC_EDGE_DELAY    = 16'hfe4c;
  localparam logic [15:0] OFS_LINE_V_HYST        = 16'hfe4d;
  localparam logic [15:0] OFS_POWER_HYST         = 16'hfe4e;
  localparam logic [15:0] OFS_FEATURE_ENABLE     = 16'hfe4f;

  // register file shape
  localparam int          NUM_REGS  = 16;
  localparam logic [7:0]  REG_RESET = 8'h00;

  // feature enable bit positions
  localparam int FE_DITHER      = 0;
  localparam int FE_SYNC        = 1;
  localparam int FE_SMART_VOUT  = 2;
  localparam int FE_SMART_FREQ  = 3;
  localparam int FE_PHASE_SHED  = 4;
  localparam int FE_LIGHT_FILT  = 5;
  localparam int FE_FEEDFORWARD = 6;

  // timing counts
  localparam int          SYNC_AVG_CYCLES   = 7;
  localparam logic [2:0]  LIGHT_LINE_CYCLES = 3'h4;
  localparam int          PER_W             = 12;

  // synchroniser states
  typedef enum logic [1:0] {
    SYNC_FREE   = 2'b00,
    SYNC_FREQ   = 2'b01,
    SYNC_PHASE  = 2'b10,
    SYNC_LOCKED = 2'b11
  } sync_state_t;

  // status flags handed to the pwm core
  typedef struct packed {
    logic locked;
    logic feedforward;
    logic light_filter;
    logic light_freq;
    logic shed;
  } feature_status_t;

endpackage

//--- pfc_adv_features.sv
`timescale 1ns/10ps
`default_nettype none
module pfc_adv_features
  import pfc_adv_pkg::*;
(
  // clock, reset, enable
  input  wire logic              sys_clk,
  input  wire logic              rst,
  input  wire logic              clk_en,
  // register command port
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  input  wire logic [15:0]       reg_addr,
  input  wire logic [7:0]        reg_wdata,
  output logic      [7:0]        reg_rdata_q,
  output logic                   reg_hit_q,
  // operating inputs
  input  wire logic              soft_start,
  input  wire logic              sync_in,
  input  wire logic [PER_W-1:0]  nominal_period,
  input  wire logic [7:0]        rect_line_voltage,
  input  wire logic [7:0]        rms_vin,
  input  wire logic [7:0]        input_power,
  input  wire logic [7:0]        super_high_line_level,
  input  wire logic [7:0]        high_line_level,
  input  wire logic [7:0]        low_line_level,
  input  wire logic [7:0]        vout_nominal,
  input  wire logic              line_cycle_tick,
  // gate drive from pwm core
  input  wire logic              bridgeless_mode,
  input  wire logic              line_phase_sense,
  input  wire logic              line_phase_valid,
  input  wire logic              pwm_a_in,
  input  wire logic              pwm_b_in,
  // results
  output logic                   cycle_start_q,
  output logic [PER_W-1:0]       active_period_q,
  output logic [7:0]             vout_setpoint_q,
  output feature_status_t        status_q,
  output logic                   first_power_switch_q,
  output logic                   second_power_switch_q
);

  // register file, one entry per offset
  localparam logic [NUM_REGS-1:0][15:0] REG_OFS = {
    OFS_FEATURE_ENABLE, OFS_POWER_HYST, OFS_LINE_V_HYST, OFS_SYNC_EDGE_DELAY,
    OFS_FLAT_TOP_V, OFS_HIGH_LINE_UPPER_V, OFS_HIGH_LINE_LOWER_V, OFS_LOW_LINE_UPPER_V,
    OFS_LOW_LINE_LOWER_V, OFS_UPPER_POWER_BP, OFS_LOWER_POWER_BP, OFS_LOW_POWER_THRESH,
    OFS_SYNC_DIVIDER, OFS_DITHER_PERIOD, OFS_LIGHT_LOAD_FREQ, OFS_SYNC_PERIOD_LIMIT};
  logic [7:0]          regs_q [NUM_REGS];  // stored register values
  logic [NUM_REGS-1:0] hit;                // address match per entry
  logic [7:0]          rd_mux;             // selected read value

  // per-entry decode and storage
  genvar gi;
  generate
    for (gi = 0; gi < NUM_REGS; gi++) begin : g_reg
      assign hit[gi] = (reg_addr == REG_OFS[gi]);
      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          regs_q[gi] <= REG_RESET;
        end else if (clk_en && reg_wr && hit[gi]) begin
          regs_q[gi] <= reg_wdata;
        end
      end
    end
  endgenerate

  // one-hot read select, unmapped reads zero
  always_comb begin
    rd_mux = 8'h00;
    for (int i = 0; i < NUM_REGS; i++) begin
      if (hit[i]) begin
        rd_mux = regs_q[i];
      end
    end
  end

  // named views of the register file
  wire [7:0] sync_period_limit       = regs_q[0];
  wire [7:0] light_load_frequency    = regs_q[1];
  wire [7:0] dither_period           = regs_q[2];
  wire [7:0] sync_divider            = regs_q[3];
  wire [7:0] low_power_threshold     = regs_q[4];
  wire [7:0] lower_power_breakpoint  = regs_q[5];
  wire [7:0] upper_power_breakpoint  = regs_q[6];
  wire [7:0] low_line_lower_voltage  = regs_q[7];
  wire [7:0] low_line_upper_voltage  = regs_q[8];
  wire [7:0] high_line_lower_voltage = regs_q[9];
  wire [7:0] high_line_upper_voltage = regs_q[10];
  wire [7:0] flat_top_voltage        = regs_q[11];
  wire [7:0] sync_edge_delay         = regs_q[12];
  wire [7:0] line_voltage_hysteresis = regs_q[13];
  wire [7:0] power_hysteresis        = regs_q[14];
  wire [7:0] feature_enable          = regs_q[15];

  // registered read answer
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      reg_rdata_q <= 8'h00;
      reg_hit_q   <= 1'b0;
    end else if (clk_en && reg_rd) begin
      reg_rdata_q <= rd_mux;
      reg_hit_q   <= |hit;
    end
  end

  // feature enables, bridgeless has none
  wire dither_en = feature_enable[FE_DITHER];
  wire sync_en   = feature_enable[FE_SYNC];
  wire svout_en  = feature_enable[FE_SMART_VOUT];
  wire sfreq_en  = feature_enable[FE_SMART_FREQ];
  wire shed_en   = feature_enable[FE_PHASE_SHED];
  wire lfilt_en  = feature_enable[FE_LIGHT_FILT];

  // capture window around the programmed period
  wire [PER_W-1:0] nom_eighth = nominal_period >> 3;
  wire [PER_W-1:0] per_min    = nominal_period - nom_eighth;  // 87.5 percent
  wire [PER_W-1:0] per_max    = nominal_period + nom_eighth;  // 112.5 percent
  wire [PER_W-1:0] limit_per  = {sync_period_limit, 4'h0};    // limit register scale

  // dither: ramp sampled from rectified line every dither_period+1 cycles
  logic [7:0]       ramp_q;    // held line sample
  logic [7:0]       dtick_q;   // sample interval counter
  wire  [PER_W+7:0] quarter_x = PER_W'(nominal_period >> 2) * ramp_q;
  wire  [PER_W-1:0] dith_per  = per_min + quarter_x[PER_W+7:8];
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ramp_q  <= 8'h00;
      dtick_q <= 8'h00;
    end else if (clk_en) begin
      if (dtick_q >= dither_period) begin
        dtick_q <= 8'h00;
        ramp_q  <= rect_line_voltage;
      end else begin
        dtick_q <= dtick_q + 8'h01;
      end
    end
  end

  // sync edge detect and period measurement
  sync_state_t      st_q;      // synchroniser state
  logic             sync_d1_q; // previous sync level
  logic [PER_W-1:0] meas_q;    // cycles since last edge
  logic [PER_W+2:0] sum_q;     // accumulated periods
  logic [2:0]       nper_q;    // periods accumulated
  logic [PER_W-1:0] avg_q;     // averaged sync period
  logic             lost_q;    // fallback to limit period
  wire              sync_rise = sync_in & ~sync_d1_q;
  wire              sync_use  = sync_en & ~soft_start;
  wire [1:0]        div_sel   = sync_divider[1:0];
  wire [PER_W+1:0]  meas_x    = meas_q * ({1'b0, div_sel} + 3'h1);
  wire              in_range  = (meas_x >= (PER_W+2)'(per_min)) &&
                                (meas_x <= (PER_W+2)'(per_max));
  wire              timeout   = (meas_q > per_max);
  wire              bad_edge  = sync_rise & ~in_range;
  wire [PER_W+2:0]  sum_next  = sum_q + (PER_W+3)'(meas_q);

  // delayed edge generator
  logic [7:0]       dly_q;     // remaining delay
  logic             dly_run_q; // delay in progress
  logic [1:0]       divc_q;    // divided edges seen
  wire              dly_edge  = dly_run_q && (dly_q == 8'h00);
  wire              div_edge  = dly_edge && (divc_q == div_sel);

  // internal switching cycle counter
  logic [PER_W-1:0] cyc_q;     // position in cycle
  logic [PER_W-1:0] per_sel;   // free-running period
  wire              cyc_end   = (cyc_q + PER_W'(1) >= per_sel);
  wire              sync_end  = (st_q == SYNC_LOCKED) && div_edge;
  wire              phase_end = (st_q == SYNC_PHASE) && div_edge;
  wire              new_cycle = sync_end | phase_end |
                                ((st_q != SYNC_LOCKED) && cyc_end);

  // free-running period choice
  always_comb begin
    if (sync_en && lost_q) begin
      per_sel = limit_per;
    end else if (sfreq_en && status_q.light_freq) begin
      per_sel = {light_load_frequency, 4'h0};
    end else if (dither_en) begin
      per_sel = dith_per;
    end else begin
      per_sel = nominal_period;
    end
  end

  // edge history and measurement counter
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sync_d1_q <= 1'b0;
      meas_q    <= '0;
    end else if (clk_en) begin
      sync_d1_q <= sync_in;
      meas_q    <= sync_rise ? PER_W'(1) : (timeout ? meas_q : meas_q + PER_W'(1));
    end
  end

  // delay from sync edge to cycle start, then divide
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      dly_q     <= 8'h00;
      dly_run_q <= 1'b0;
      divc_q    <= 2'b00;
    end else if (clk_en) begin
      if (sync_rise) begin
        dly_q     <= sync_edge_delay;
        dly_run_q <= 1'b1;
      end else if (dly_edge) begin
        dly_run_q <= 1'b0;
      end else if (dly_run_q) begin
        dly_q <= dly_q - 8'h01;
      end
      if (!sync_use || st_q == SYNC_FREQ) begin
        divc_q <= 2'b00;
      end else if (dly_edge) begin
        divc_q <= (divc_q == div_sel) ? 2'b00 : divc_q + 2'b01;
      end
    end
  end

  // frequency capture, phase capture, pulse-by-pulse lock
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_q   <= SYNC_FREE;
      sum_q  <= '0;
      nper_q <= 3'h0;
      avg_q  <= '0;
      lost_q <= 1'b0;
    end else if (clk_en) begin
      if (!sync_use) begin
        st_q   <= SYNC_FREE;
        lost_q <= 1'b0;
      end else begin
        case (st_q)
          SYNC_FREE: begin
            if (sync_rise) begin
              st_q   <= SYNC_FREQ;
              sum_q  <= '0;
              nper_q <= 3'h0;
            end
          end
          SYNC_FREQ: begin
            if (timeout || bad_edge) begin
              st_q   <= SYNC_FREE;
              lost_q <= 1'b1;
            end else if (sync_rise) begin
              sum_q  <= sum_next;
              nper_q <= nper_q + 3'h1;
              if (nper_q == 3'(SYNC_AVG_CYCLES - 1)) begin
                avg_q <= PER_W'(sum_next / 3'(SYNC_AVG_CYCLES));
                st_q  <= SYNC_PHASE;
              end
            end
          end
          SYNC_PHASE: begin
            if (timeout || bad_edge) begin
              st_q   <= SYNC_FREE;
              lost_q <= 1'b1;
            end else if (div_edge) begin
              st_q   <= SYNC_LOCKED;
              lost_q <= 1'b0;
            end
          end
          SYNC_LOCKED: begin
            if (timeout || bad_edge) begin
              st_q   <= SYNC_FREE;
              lost_q <= 1'b1;
            end
          end
          default: st_q <= SYNC_FREE;
        endcase
      end
    end
  end

  // cycle counter and period reporting
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cyc_q           <= '0;
      cycle_start_q   <= 1'b0;
      active_period_q <= '0;
    end else if (clk_en) begin
      cycle_start_q <= new_cycle;
      cyc_q         <= new_cycle ? '0 : cyc_q + PER_W'(1);
      if (new_cycle) begin
        active_period_q <= (st_q == SYNC_LOCKED) ? PER_W'(cyc_q + PER_W'(1)) : per_sel;
      end
    end
  end

  // power comparisons with hysteresis
  wire [8:0] p_up  = {1'b0, low_power_threshold} + {1'b0, power_hysteresis};
  wire       p_low = input_power < low_power_threshold;
  wire       p_hi  = {1'b0, input_power} > p_up;

  // super high line flag with voltage hysteresis
  logic      shl_q;  // above super high line
  wire [8:0] shl_dn = {1'b0, super_high_line_level} - {1'b0, line_voltage_hysteresis};
  wire       shl_set = rms_vin > super_high_line_level;
  wire       shl_clr = $signed({1'b0, rms_vin}) < $signed(shl_dn);

  // load line interpolation between breakpoints
  logic [7:0]  v_lo;    // voltage below lower breakpoint
  logic [7:0]  v_hi;    // voltage above upper breakpoint
  logic [7:0]  sp_next; // setpoint to load
  wire  [7:0]  p_span   = upper_power_breakpoint - lower_power_breakpoint;
  wire  [7:0]  p_off    = input_power - lower_power_breakpoint;
  wire  signed [9:0]  v_span = $signed({2'b00, v_hi}) - $signed({2'b00, v_lo});
  wire  signed [18:0] v_prod = v_span * $signed({1'b0, p_off});
  wire  signed [18:0] v_step = (p_span == 8'h00) ? 19'sh0_0000 :
                               v_prod / $signed({11'h000, p_span});
  wire  signed [18:0] v_lerp = $signed({11'h000, v_lo}) + v_step;
  wire         high_line = rms_vin > high_line_level;

  // setpoint selection
  always_comb begin
    if (high_line) begin
      v_lo = high_line_lower_voltage;
      v_hi = high_line_upper_voltage;
    end else begin
      v_lo = low_line_lower_voltage;
      v_hi = low_line_upper_voltage;
    end
    if (!svout_en) begin
      sp_next = vout_nominal;
    end else if (shl_q) begin
      sp_next = flat_top_voltage;
    end else if (input_power <= lower_power_breakpoint) begin
      sp_next = v_lo;
    end else if (input_power >= upper_power_breakpoint) begin
      sp_next = v_hi;
    end else begin
      sp_next = v_lerp[7:0];
    end
  end

  // light load state and setpoint registers
  logic [2:0] llc_q;  // line cycles spent below threshold
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      shl_q           <= 1'b0;
      vout_setpoint_q <= 8'h00;
      llc_q           <= 3'h0;
      status_q        <= '0;
    end else if (clk_en) begin
      if (shl_set) begin
        shl_q <= 1'b1;
      end else if (shl_clr) begin
        shl_q <= 1'b0;
      end
      vout_setpoint_q <= sp_next;
      // smart frequency flag
      if (!sfreq_en || p_hi) begin
        status_q.light_freq <= 1'b0;
      end else if (p_low) begin
        status_q.light_freq <= 1'b1;
      end
      // phase shedding flag
      if (!shed_en || p_hi) begin
        status_q.shed <= 1'b0;
      end else if (p_low) begin
        status_q.shed <= 1'b1;
      end
      // light load filter after four line cycles
      if (!lfilt_en || p_hi) begin
        status_q.light_filter <= 1'b0;
        llc_q                 <= 3'h0;
      end else if (!p_low) begin
        llc_q <= 3'h0;
      end else if (line_cycle_tick && !status_q.light_filter) begin
        llc_q <= llc_q + 3'h1;
        if (llc_q + 3'h1 == LIGHT_LINE_CYCLES) begin
          status_q.light_filter <= 1'b1;
        end
      end
      status_q.feedforward <= feature_enable[FE_FEEDFORWARD];
      status_q.locked      <= (st_q == SYNC_LOCKED);
    end
  end

  // gate steering
  wire phase_ok = line_phase_valid & ~soft_start;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      first_power_switch_q  <= 1'b0;
      second_power_switch_q <= 1'b0;
    end else if (clk_en) begin
      if (!bridgeless_mode) begin
        first_power_switch_q  <= pwm_a_in;
        second_power_switch_q <= pwm_b_in & ~status_q.shed;
      end else if (!phase_ok) begin
        first_power_switch_q  <= pwm_a_in;
        second_power_switch_q <= pwm_a_in;
      end else if (line_phase_sense) begin
        first_power_switch_q  <= pwm_a_in;
        second_power_switch_q <= 1'b1;
      end else begin
        first_power_switch_q  <= 1'b1;
        second_power_switch_q <= pwm_a_in;
      end
    end
  end

  // assertions
  property p_ff_follows;
    @(posedge sys_clk) disable iff (rst)
    clk_en |=> status_q.feedforward == $past(feature_enable[FE_FEEDFORWARD]);
  endproperty
  a_ff_follows: assert property (p_ff_follows) else $error("feedforward bit");

  property p_shed_needs_en;
    @(posedge sys_clk) disable iff (rst)
    clk_en && !shed_en |=> !status_q.shed;
  endproperty
  a_shed_needs_en: assert property (p_shed_needs_en) else $error("shed while off");

  property p_soft_free;
    @(posedge sys_clk) disable iff (rst)
    clk_en && soft_start |=> st_q == SYNC_FREE;
  endproperty
  a_soft_free: assert property (p_soft_free) else $error("sync in soft start");

  sequence s_bad_phase;
    clk_en && bridgeless_mode && (!line_phase_valid || soft_start);
  endsequence
  property p_both_switch;
    @(posedge sys_clk) disable iff (rst)
    s_bad_phase |=> first_power_switch_q == second_power_switch_q;
  endproperty
  a_both_switch: assert property (p_both_switch) else $error("switches differ");

  property p_pos_phase;
    @(posedge sys_clk) disable iff (rst)
    clk_en && bridgeless_mode && phase_ok && line_phase_sense |=> second_power_switch_q;
  endproperty
  a_pos_phase: assert property (p_pos_phase) else $error("second not on");

  property p_neg_phase;
    @(posedge sys_clk) disable iff (rst)
    clk_en && bridgeless_mode && phase_ok && !line_phase_sense |=> first_power_switch_q;
  endproperty
  a_neg_phase: assert property (p_neg_phase) else $error("first not on");

  property p_flat_top;
    @(posedge sys_clk) disable iff (rst)
    clk_en && svout_en && shl_q |=> vout_setpoint_q == $past(flat_top_voltage);
  endproperty
  a_flat_top: assert property (p_flat_top) else $error("flat top not held");

  property p_filter_up;
    @(posedge sys_clk) disable iff (rst)
    clk_en && p_hi |=> !status_q.light_filter;
  endproperty
  a_filter_up: assert property (p_filter_up) else $error("filter not restored");

  property p_lock_order;
    @(posedge sys_clk) disable iff (rst)
    clk_en && st_q == SYNC_FREQ && $past(st_q) == SYNC_FREE |-> nper_q == 3'h0;
  endproperty
  a_lock_order: assert property (p_lock_order) else $error("capture not reset");

  property p_lost_period;
    @(posedge sys_clk) disable iff (rst)
    clk_en && sync_en && lost_q && new_cycle && st_q != SYNC_LOCKED
      |=> active_period_q == $past(limit_per);
  endproperty
  a_lost_period: assert property (p_lost_period) else $error("no limit fallback");

endmodule
`default_nettype wire

//--- sync_source.sv
`timescale 1ns/10ps
`default_nettype none
// external sync generator on the far side of the synchroniser
module sync_source (
  // clock and control
  input  wire logic        sys_clk,
  input  wire logic        run,
  input  wire logic [11:0] period,
  // sync line
  output var logic         sync_out
);
  int cnt;  // cycles into the current sync period
  initial cnt = 0;
  initial sync_out = 1'b0;
  // quarter-period high pulse; line stands low while stopped
  always @(negedge sys_clk) begin
    cnt <= (!run || cnt >= int'(period) - 1) ? 0 : cnt + 1;
    sync_out <= run && (cnt < int'(period) / 4);
  end
endmodule
`default_nettype wire

//--- pfc_advanced_pwm_features_tb.sv
`timescale 1ns/10ps
`default_nettype none
module pfc_advanced_pwm_features_tb;
  import pfc_adv_pkg::*;
  // stimulus
  logic sys_clk = '0, rst = '1, clk_en = '1, reg_wr = '0, reg_rd = '0, soft_start = '0;
  logic line_cycle_tick = '0, bridgeless_mode = '0, line_phase_sense = '0, line_phase_valid = '1;
  logic pwm_a_in = '0, pwm_b_in = '0, run = '0, sync_in;
  logic [15:0] reg_addr = '0;
  logic [7:0] reg_wdata = '0, rect_line_voltage = 8'h80, rms_vin = '0, input_power = '0;
  logic [7:0] super_high_line_level = 8'hc0, high_line_level = 8'h90, low_line_level = 8'h60;
  logic [7:0] vout_nominal = 8'h55;
  logic [PER_W-1:0] nominal_period = 12'h064, sync_per = 12'h032;
  // observed
  logic [7:0] reg_rdata_q, vout_setpoint_q;
  logic reg_hit_q, cycle_start_q, first_power_switch_q, second_power_switch_q;
  logic [PER_W-1:0] active_period_q;
  feature_status_t status_q;
  int miscompares = 0, n_checks = 0, cyc = 0, n;
  // register map and the configuration written to it
  logic [15:0] ofs [16] = '{OFS_SYNC_PERIOD_LIMIT, OFS_LIGHT_LOAD_FREQ, OFS_DITHER_PERIOD,
    OFS_SYNC_DIVIDER, OFS_LOW_POWER_THRESH, OFS_LOWER_POWER_BP, OFS_UPPER_POWER_BP,
    OFS_LOW_LINE_LOWER_V, OFS_LOW_LINE_UPPER_V, OFS_HIGH_LINE_LOWER_V, OFS_HIGH_LINE_UPPER_V,
    OFS_FLAT_TOP_V, OFS_SYNC_EDGE_DELAY, OFS_LINE_V_HYST, OFS_POWER_HYST, OFS_FEATURE_ENABLE};
  logic [7:0] val [16] = '{8'h08, 8'h04, 8'h00, 8'h01, 8'h40, 8'h20, 8'h80, 8'h30, 8'h50,
    8'h70, 8'h90, 8'hb0, 8'h03, 8'h08, 8'h10, 8'h00};

  pfc_adv_features u_dut (.sys_clk, .rst, .clk_en, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .reg_rdata_q, .reg_hit_q, .soft_start, .sync_in, .nominal_period, .rect_line_voltage,
    .rms_vin, .input_power, .super_high_line_level, .high_line_level, .low_line_level,
    .vout_nominal, .line_cycle_tick, .bridgeless_mode, .line_phase_sense, .line_phase_valid,
    .pwm_a_in, .pwm_b_in, .cycle_start_q, .active_period_q, .vout_setpoint_q, .status_q,
    .first_power_switch_q, .second_power_switch_q);
  sync_source u_sync (.sys_clk, .run, .period(sync_per), .sync_out(sync_in));

  // 25 MHz clock
  initial forever #20 sys_clk = ~sys_clk;

  task automatic conclude;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // hang guard
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      conclude();
    end
  end

  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic idle(input int k);
    repeat (k) @(negedge sys_clk);
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    idle(1);
    reg_wr = 1'b0;
    idle(1);
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e, input logic h);
    reg_addr = a;
    reg_rd = 1'b1;
    idle(1);
    reg_rd = 1'b0;
    chk(reg_rdata_q, e);
    chk(reg_hit_q, h);
    idle(1);
  endtask
  // setpoint for one line and load point
  task automatic sv(input logic [7:0] r, input logic [7:0] p, input logic [7:0] e);
    rms_vin = r;
    input_power = p;
    idle(4);
    chk(vout_setpoint_q, e);
  endtask
  // gate steering for one phase condition
  task automatic bl(input logic ph, v, s, a, e1, e2);
    line_phase_sense = ph;
    line_phase_valid = v;
    soft_start = s;
    pwm_a_in = a;
    idle(3);
    chk(first_power_switch_q, e1);
    chk(second_power_switch_q, e2);
  endtask
  task automatic tick(input logic e);
    line_cycle_tick = 1'b1;
    idle(1);
    line_cycle_tick = 1'b0;
    idle(3);
    chk(status_q.light_filter, e);
  endtask

  initial begin
    idle(16);
    rst = 1'b0;
    idle(2);
    chk(vout_setpoint_q, vout_nominal);
    for (int i = 0; i < 16; i++) begin
      rd(ofs[i], 8'h00, 1'b1);
      wr(ofs[i], val[i]);
      rd(ofs[i], val[i], 1'b1);
    end
    wr(16'hfe4b, 8'h5a);
    rd(16'hfe4b, 8'h00, 1'b0);
    wr(OFS_FEATURE_ENABLE, 8'h40);
    idle(3);
    chk(status_q.feedforward, 1'b1);
    chk(status_q.shed, 1'b0);
    chk(status_q.light_freq, 1'b0);
    // a write with the clock enable low must not land
    clk_en = 1'b0;
    wr(OFS_FEATURE_ENABLE, 8'h00);
    clk_en = 1'b1;
    rd(OFS_FEATURE_ENABLE, 8'h40, 1'b1);
    wr(OFS_FEATURE_ENABLE, 8'h04);
    sv(8'hd0, 8'h10, 8'hb0);
    sv(8'hbc, 8'hf0, 8'hb0);
    sv(8'ha0, 8'h10, 8'h70);
    sv(8'ha0, 8'h50, 8'h80);
    sv(8'ha0, 8'hf0, 8'h90);
    sv(8'h40, 8'h10, 8'h30);
    sv(8'h40, 8'hf0, 8'h50);
    wr(OFS_FEATURE_ENABLE, 8'h38);
    pwm_b_in = 1'b1;
    input_power = 8'h30;
    for (int i = 1; i < 5; i++) tick(i == 4);
    chk(status_q.shed, 1'b1);
    chk(status_q.light_freq, 1'b1);
    chk(second_power_switch_q, 1'b0);
    input_power = 8'h48;
    idle(3);
    chk(status_q.shed, 1'b1);
    input_power = 8'h58;
    idle(3);
    chk(status_q.light_freq, 1'b0);
    chk(status_q.light_filter, 1'b0);
    chk(second_power_switch_q, 1'b1);
    bridgeless_mode = 1'b1;
    bl(1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1);
    bl(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
    bl(1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
    bl(1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1);
    bl(1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
    bridgeless_mode = 1'b0;
    wr(OFS_FEATURE_ENABLE, 8'h02);
    run = 1'b1;
    idle(1500);
    chk(status_q.locked, 1'b0);
    soft_start = 1'b0;
    n = 0;
    while (status_q.locked !== 1'b1 && n < 3000) begin
      idle(1);
      n++;
    end
    chk(status_q.locked, 1'b1);
    n = 0;
    repeat (1000) begin
      idle(1);
      n += int'(cycle_start_q === 1'b1);
    end
    chk(12'(n), 12'h00a);
    run = 1'b0;
    idle(300);
    chk(status_q.locked, 1'b0);
    n = 0;
    while (cycle_start_q !== 1'b1 && n < 500) begin
      idle(1);
      n++;
    end
    chk(active_period_q, 12'h080);
    // dither end points: 88 and 112 cycles of a 100-cycle period
    wr(OFS_FEATURE_ENABLE, 8'h01);
    rect_line_voltage = 8'h00;
    idle(300);
    chk(active_period_q, 12'h058);
    rect_line_voltage = 8'hff;
    idle(300);
    chk(active_period_q, 12'h070);
    conclude();
  end
endmodule
`default_nettype wire
